/* core/dac_cal_params.svh */
`ifndef DAC_CAL_PARAMS_SVH
`define DAC_CAL_PARAMS_SVH

// coefficient bank shape
`define CAL_COEF_W 24
`define CAL_NUM_COEF 24
`define CAL_DAC_W 18
`define CAL_LEVEL_W 20

// register word indexes, byte address is four times the index
`define CAL_GAIN_BASE 8'h80
`define CAL_OFFS_BASE 8'h90
`define CAL_SPARE_BASE 8'hA0
`define CAL_CFG_IDX 8'h10
`define CAL_CODE_IDX 8'h11
`define CAL_RELOAD_IDX 8'h12
`define CAL_STAT_IDX 8'h13

// io_path_config fields
`define CFG_UNI_BIT 0
`define CFG_CUR_BIT 1
`define CFG_RES16_BIT 2
// status field holding the preload busy flag
`define STAT_BUSY_BIT 20

// reset values
`define CAL_GAIN_RST 24'h40_0000
`define CAL_OTHER_RST 24'h00_0000
// 18.75 V (or 37.5 mA) in 18-bit step units
`define CAL_UNI_MID 20'sh3_0000

`endif

/* core/dac_cal_pkg.sv */
`include "dac_cal_params.svh"

package dac_cal_pkg;
    typedef logic [`CAL_NUM_COEF-1:0][`CAL_COEF_W-1:0] coef_bank_t;

    typedef struct packed {
        coef_bank_t coef;
        logic unipolar;
        logic current;
        logic res16;
        logic [`CAL_DAC_W-1:0] code;
        logic signed [`CAL_LEVEL_W-1:0] level;
        logic [`CAL_DAC_W-1:0] gain;
        logic [`CAL_DAC_W-1:0] ofs;
        logic ack;
        logic [31:0] rdat;
        logic reload;
    } core_state_t;

    typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_WAIT} ld_phase_t;

    typedef struct packed {
        ld_phase_t phase;
        logic [4:0] idx;
        logic busy;
        logic rd;
        logic we;
        logic [4:0] widx;
        logic [`CAL_COEF_W-1:0] data;
    } ld_state_t;
endpackage : dac_cal_pkg

/* core/dac_code_map.sv */
// Functional notes
// R1: 18-bit codes +131071..-131072, positive drives negative
// R2: 16-bit codes +32767..-32768, same inverted ends
// R3: 18-bit voltage step is 25 V over 2^18
// R4: 18-bit current step is 50 mA over 2^18
// R5: config bit one selects unipolar transfer; the code uses bit zero, bit one selects current
// R6: unipolar voltage is 18.75 V minus code steps
// R7: unipolar current is 37.5 mA minus code steps
// R8: 24 coefficients: eight gain, offset, spare each
// R9: every coefficient register is 24 bits wide
// R10: output path uses upper 18 coefficient bits
// R11: software reads and writes every coefficient
// R12: reset copies stored values into coefficients
// R13: output code is signed two's complement, max 18
// R14: reload command recopies stored coefficient values
// R15: reads return last write or preloaded value
`timescale 1ns/100ps
`include "dac_cal_params.svh"

module dac_code_map #(
    parameter int ADR_W = 10
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // wishbone classic slave
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // nonvolatile coefficient store
    output logic [4:0] nvm_addr,
    output logic nvm_rd,
    input wire logic [`CAL_COEF_W-1:0] nvm_rdata,
    input wire logic nvm_ack,
    input wire logic nvm_hit,
    // converter side
    output logic signed [`CAL_LEVEL_W-1:0] output_level,
    output logic current_mode,
    output logic [`CAL_DAC_W-1:0] dac_gain,
    output logic [`CAL_DAC_W-1:0] dac_offset,
    output logic preload_busy
);
    import dac_cal_pkg::*;

    if (ADR_W < 10 || ADR_W > 32) begin : g_bad_adr
        $error("dac_code_map: ADR_W must be 10..32");
    end

    localparam core_state_t CORE_RST = '{
        coef: {{16{`CAL_OTHER_RST}}, {8{`CAL_GAIN_RST}}},
        unipolar: 1'b0, current: 1'b0, res16: 1'b0,
        code: 18'h0_0000, level: 20'sh0_0000,
        gain: 18'h1_0000, ofs: 18'h0_0000,
        ack: 1'b0, rdat: 32'h0000_0000, reload: 1'b0};

    core_state_t s_q, s_d;
    logic ld_busy;
    logic ld_we;
    logic [4:0] ld_idx;
    logic [`CAL_COEF_W-1:0] ld_data;
    logic req;
    logic [7:0] widx;
    logic [5:0] slot;
    logic signed [`CAL_LEVEL_W-1:0] scaled;
    logic [31:0] wmerged;

    // map a word index onto the coefficient bank
    function automatic logic [5:0] coef_slot(input logic [7:0] idx);
        logic [7:0] base;
        base = {idx[7:3], 3'b000};
        if (base == `CAL_GAIN_BASE) begin
            coef_slot = {1'b1, 2'b00, idx[2:0]};
        end else if (base == `CAL_OFFS_BASE) begin
            coef_slot = {1'b1, 2'b01, idx[2:0]};
        end else if (base == `CAL_SPARE_BASE) begin
            coef_slot = {1'b1, 2'b10, idx[2:0]};
        end else begin
            coef_slot = 6'h00;
        end
    endfunction : coef_slot

    // byte-lane merge of a write into the old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] sel);
        lane_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                lane_merge[8*b +: 8] = wd[8*b +: 8];
            end
        end
    endfunction : lane_merge

    // preload and reload sequencer
    nvm_preload #(
        .NUM(`CAL_NUM_COEF)
    ) u_preload (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .start(s_q.reload),
        .nvm_addr(nvm_addr),
        .nvm_rd(nvm_rd),
        .nvm_rdata(nvm_rdata),
        .nvm_ack(nvm_ack),
        .nvm_hit(nvm_hit),
        .busy(ld_busy),
        .ld_we(ld_we),
        .ld_idx(ld_idx),
        .ld_data(ld_data)
    );

    // bus waits while the bank is being loaded
    assign req = wb_cyc_i && wb_stb_i && !s_q.ack && !ld_busy && !ld_we
        && !s_q.reload;
    assign widx = wb_adr_i[9:2];
    assign slot = coef_slot(widx);

    // code widened to 18-bit step units, 16-bit steps are four times larger
    always_comb begin
        if (s_q.res16) begin
            scaled = {{2{s_q.code[15]}}, s_q.code[15:0], 2'b00}; // [R2] [R13]
        end else begin
            scaled = {{2{s_q.code[17]}}, s_q.code}; // [R1] [R13]
        end
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        wmerged = 32'h0000_0000;
        // transfer map, inverted for bipolar, offset for unipolar
        if (s_q.unipolar) begin
            s_d.level = `CAL_UNI_MID - scaled; // [R5] [R6] [R7]
        end else begin
            s_d.level = -scaled; // [R1] [R3] [R4]
        end
        // converter takes the top bits of pointer 0 or 1
        s_d.gain = s_q.coef[{4'h0, s_q.current}][23:6]; // [R10]
        s_d.ofs = s_q.coef[{4'b0100, s_q.current}][23:6]; // [R10]
        // reload request leaves once the sequencer takes it
        if (s_q.reload && !ld_busy) begin
            s_d.reload = 1'b0;
        end
        // stored value lands in the bank
        if (ld_we) begin
            s_d.coef[ld_idx] = ld_data; // [R12] [R14]
        end
        if (req) begin
            s_d.ack = 1'b1;
            s_d.rdat = 32'h0000_0000;
            if (slot[5]) begin
                wmerged = lane_merge({8'h00, s_q.coef[slot[4:0]]},
                    wb_dat_i, wb_sel_i);
                if (wb_we_i) begin
                    s_d.coef[slot[4:0]] = wmerged[23:0]; // [R9] [R11]
                end else begin
                    s_d.rdat = {8'h00, s_q.coef[slot[4:0]]}; // [R11] [R15]
                end
            end else begin
                case (widx)
                    `CAL_CFG_IDX: begin
                        if (wb_we_i && wb_sel_i[0]) begin
                            s_d.unipolar = wb_dat_i[`CFG_UNI_BIT]; // [R5]
                            s_d.current = wb_dat_i[`CFG_CUR_BIT];
                            s_d.res16 = wb_dat_i[`CFG_RES16_BIT];
                        end
                        s_d.rdat = {29'h0000_0000, s_q.res16, s_q.current,
                            s_q.unipolar};
                    end
                    `CAL_CODE_IDX: begin
                        wmerged = lane_merge({14'h0000, s_q.code},
                            wb_dat_i, wb_sel_i);
                        if (wb_we_i) begin
                            s_d.code = wmerged[17:0]; // [R13]
                        end
                        s_d.rdat = {14'h0000, s_q.code};
                    end
                    `CAL_RELOAD_IDX: begin
                        if (wb_we_i && wb_sel_i[0] && wb_dat_i[0]) begin
                            s_d.reload = 1'b1; // [R14]
                        end
                    end
                    `CAL_STAT_IDX: begin
                        s_d.rdat = {11'h000, ld_busy, s_q.level};
                    end
                    default: s_d.rdat = 32'h0000_0000;
                endcase
            end
            if (wb_we_i) begin
                s_d.rdat = 32'h0000_0000;
            end
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= CORE_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register, preload_busy from the sequencer's state register
    assign wb_dat_o = s_q.rdat;
    assign wb_ack_o = s_q.ack;
    assign output_level = s_q.level;
    assign current_mode = s_q.current;
    assign dac_gain = s_q.gain;
    assign dac_offset = s_q.ofs;
    assign preload_busy = ld_busy;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_ack_single_pulse: assert property ( // [R11]
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_after_req: assert property ( // [R11]
        (ce && req) |=> wb_ack_o)
        else $error("accepted request not answered next cycle");

    a_coef_write_lands: assert property ( // [R11]
        (ce && req && wb_we_i && slot[5] && wb_sel_i == 4'hf)
        ##1 ce [*2] |=> s_q.coef[$past(slot[4:0], 3)]
            == $past(wb_dat_i[23:0], 3))
        else $error("coefficient write not readable back");

    a_coef_read_value: assert property ( // [R15]
        (ce && req && !wb_we_i && slot[5]) |=>
        wb_dat_o == {8'h00, $past(s_q.coef[slot[4:0]])})
        else $error("coefficient read returns wrong value");

    a_preload_lands: assert property ( // [R12]
        (ce && ld_we) |=> s_q.coef[$past(ld_idx)] == $past(ld_data))
        else $error("stored coefficient not copied");

    a_bipolar_ends: assert property ( // [R1]
        (ce && !s_q.unipolar && !s_q.res16 && s_q.code == 18'h1_ffff)
        |=> output_level == -20'sd131071)
        else $error("18-bit positive end wrong");

    a_bipolar_16_end: assert property ( // [R2]
        (ce && !s_q.unipolar && s_q.res16 && s_q.code[15:0] == 16'h8000)
        |=> output_level == 20'sd131072)
        else $error("16-bit negative end wrong");

    a_unipolar_map: assert property ( // [R6]
        (ce && s_q.unipolar) |=>
        output_level == `CAL_UNI_MID - $past(scaled))
        else $error("unipolar transfer wrong");

    a_gain_msb_used: assert property ( // [R10]
        ce |=> dac_gain == $past(s_q.coef[{4'h0, s_q.current}][23:6]))
        else $error("converter gain not upper coefficient bits");

    a_reload_starts: assert property ( // [R14]
        (ce && req && wb_we_i && widx == `CAL_RELOAD_IDX && wb_sel_i[0]
        && wb_dat_i[0]) ##1 ce [*3] |-> preload_busy)
        else $error("reload command did not start the copy");

    c_preload_done: cover property ($fell(preload_busy));
    c_unipolar_out: cover property (s_q.unipolar && output_level > 0);
    c_reload_cmd: cover property (s_q.reload ##1 preload_busy);
endmodule : dac_code_map

/* core/nvm_preload.sv */
`timescale 1ns/100ps
`include "dac_cal_params.svh"

module nvm_preload #(
    parameter int NUM = `CAL_NUM_COEF
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // reload request, taken only while idle
    input wire logic start,
    // nonvolatile store port
    output logic [4:0] nvm_addr,
    output logic nvm_rd,
    input wire logic [`CAL_COEF_W-1:0] nvm_rdata,
    input wire logic nvm_ack,
    input wire logic nvm_hit,
    // writes into the coefficient bank
    output logic busy,
    output logic ld_we,
    output logic [4:0] ld_idx,
    output logic [`CAL_COEF_W-1:0] ld_data
);
    import dac_cal_pkg::*;

    if (NUM < 1 || NUM > 32) begin : g_bad_num
        $error("nvm_preload: NUM must be 1..32");
    end

    localparam logic [4:0] LAST = 5'(NUM - 1);
    localparam ld_state_t LD_RST = '{phase: LD_REQ, idx: 5'h0, busy: 1'b1,
        rd: 1'b0, we: 1'b0, widx: 5'h0, data: `CAL_OTHER_RST};

    ld_state_t s_q, s_d;

    // walk all words once after reset and on each accepted start
    always_comb begin
        s_d = s_q;
        s_d.rd = 1'b0;
        s_d.we = 1'b0;
        case (s_q.phase)
            LD_IDLE: begin
                if (start) begin
                    s_d.phase = LD_REQ;
                    s_d.idx = 5'h0;
                    s_d.busy = 1'b1;
                end
            end
            LD_REQ: begin
                s_d.rd = 1'b1;
                s_d.phase = LD_WAIT;
            end
            LD_WAIT: begin
                if (nvm_ack) begin
                    // blank words are not written and keep their current value
                    s_d.we = nvm_hit;
                    s_d.widx = s_q.idx;
                    s_d.data = nvm_rdata;
                    if (s_q.idx == LAST) begin
                        s_d.phase = LD_IDLE;
                        s_d.busy = 1'b0;
                    end else begin
                        s_d.idx = s_q.idx + 5'h1;
                        s_d.phase = LD_REQ;
                    end
                end
            end
            default: s_d.phase = LD_IDLE;
        endcase
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= LD_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign nvm_addr = s_q.idx;
    assign nvm_rd = s_q.rd;
    assign busy = s_q.busy;
    assign ld_we = s_q.we;
    assign ld_idx = s_q.widx;
    assign ld_data = s_q.data;
endmodule : nvm_preload

/* tb/dac_code_map_tb.sv */
`timescale 1ns/100ps
`include "dac_cal_params.svh"

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
failures++; $display("Error %s expected %h seen %h", nm, e, g); end end

module dac_code_map_tb;
    import dac_cal_pkg::*;

    logic clk, resetn, ce, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [9:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i;
    logic [4:0] nvm_addr;
    logic nvm_rd, nvm_ack, nvm_hit, current_mode, preload_busy;
    logic [23:0] nvm_rdata;
    logic signed [19:0] output_level;
    logic [17:0] dac_gain, dac_offset;
    int failures = 0;
    int check_count = 0;
    logic [23:0] exp_bank [24];
    logic pend = 1'b0;
    logic [1:0] wait_n = 2'h0;
    logic [4:0] nv_a = 5'h0;
    logic [17:0] codes [7] = '{18'h1_FFFF, 18'h2_0000, 18'h0_0001,
        18'h3_FFFF, 18'h0_0000, 18'h0_7FFF, 18'h0_8000};

    dac_code_map #(.ADR_W(10)) dut_u (.clk(clk), .resetn(resetn), .ce(ce),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nvm_addr(nvm_addr),
        .nvm_rd(nvm_rd), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack),
        .nvm_hit(nvm_hit), .output_level(output_level),
        .current_mode(current_mode), .dac_gain(dac_gain),
        .dac_offset(dac_offset), .preload_busy(preload_busy));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // stored word contents and which words exist
    function automatic logic [23:0] stored(input int k);
        return 24'hA5_0000 + 24'(k) * 24'h00_0101;
    endfunction : stored

    function automatic logic word_hit(input int k);
        return (k % 5) != 3;
    endfunction : word_hit

    function automatic logic [7:0] coef_idx(input int k);
        return 8'h80 + 8'((k / 8) * 16 + k % 8);
    endfunction : coef_idx

    // expected level in 18-bit step units
    function automatic logic signed [19:0] level_of(input logic [17:0] c,
            input logic uni, input logic r16);
        logic signed [19:0] s;
        s = r16 ? {{2{c[15]}}, c[15:0], 2'b00} : {{2{c[17]}}, c};
        return uni ? 20'sh3_0000 - s : -s;
    endfunction : level_of

    // store answers 1 to 4 cycles late, stale data never lingers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend <= 1'b0;
            nvm_ack <= 1'b0;
            nvm_rdata <= 24'h00_0000;
            nvm_hit <= 1'b0;
        end else begin
            nvm_ack <= 1'b0;
            nvm_rdata <= ~nvm_rdata;
            nvm_hit <= ~nvm_hit;
            if (nvm_rd) begin
                pend <= 1'b1;
                wait_n <= nvm_addr[1:0];
                nv_a <= nvm_addr;
            end else if (pend && wait_n != 2'h0) begin
                wait_n <= wait_n - 2'h1;
            end else if (pend) begin
                pend <= 1'b0;
                nvm_ack <= 1'b1;
                nvm_rdata <= stored(nv_a);
                nvm_hit <= word_hit(nv_a);
            end
        end
    end

    task automatic tally_and_finish();
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // one classic wishbone cycle, waits for ack
    task automatic wb_xfer(input logic we, input logic [7:0] idx,
            input logic [31:0] wd, input logic [3:0] sel,
            output logic [31:0] rdat);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= wd;
        wb_sel_i <= sel;
        for (n = 0; n < 4000; n++) begin
            @(posedge clk);
            if (wb_ack_o === 1'b1) break;
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n == 4000) begin
            failures++;
            tally_and_finish();
        end
    endtask : wb_xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd,
            input logic [3:0] sel);
        logic [31:0] dummy;
        wb_xfer(1'b1, idx, wd, sel, dummy);
    endtask : wr

    task automatic chk_rd(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] r;
        wb_xfer(1'b0, idx, 32'h0000_0000, 4'hF, r);
        `CHK("register read", e, r)
    endtask : chk_rd

    task automatic check_bank();
        for (int k = 0; k < 24; k++) begin
            chk_rd(coef_idx(k), {8'h00, exp_bank[k]});
        end
    endtask : check_bank

    // reset, expected bank becomes the stored or reset values
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 0; k < 24; k++) begin
            exp_bank[k] = word_hit(k) ? stored(k) :
                (k < 8 ? 24'h40_0000 : 24'h00_0000);
        end
    endtask : do_reset

    // set mode and code, check level and exported coefficients
    task automatic mode_code(input logic [2:0] cfg, input logic [17:0] c);
        logic [31:0] r;
        logic signed [19:0] e;
        e = level_of(c, cfg[0], cfg[2]);
        wr(8'h10, {29'h0, cfg}, 4'h1);
        wr(8'h11, {14'h0, c}, 4'hF);
        wb_xfer(1'b0, 8'h13, 32'h0000_0000, 4'hF, r);
        `CHK("status level", e, r[19:0])
        `CHK("output level", e, output_level)
        `CHK("current mode", cfg[1], current_mode)
        `CHK("gain field", exp_bank[cfg[1]][23:6], dac_gain)
        `CHK("offset field", exp_bank[8 + cfg[1]][23:6], dac_offset)
    endtask : mode_code

    // main sequence
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 10'h000;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'h0;
        do_reset();
        check_bank();
        for (int k = 0; k < 24; k++) begin
            exp_bank[k] = 24'h5C_3000 ^ (24'(k) << 9) ^ 24'(k);
            wr(coef_idx(k), {8'hFF, exp_bank[k]}, 4'hF);
        end
        wr(coef_idx(2), 32'h1234_5678, 4'b0101);
        exp_bank[2] = {8'h34, exp_bank[2][15:8], 8'h78};
        check_bank();
        wr(8'h41, 32'hFFFF_FFFF, 4'hF);
        chk_rd(8'h41, 32'h0000_0000);
        for (int m = 0; m < 8; m++) begin
            for (int j = 0; j < 7; j++) begin
                mode_code(3'(m), codes[j]);
            end
            chk_rd(8'h10, 32'(m));
        end
        wr(8'h12, 32'h0000_0001, 4'h1);
        // reload without reset: stored words return, blank words keep value
        for (int k = 0; k < 24; k++) begin
            if (word_hit(k)) exp_bank[k] = stored(k);
        end
        check_bank();
        chk_rd(8'h12, 32'h0000_0000);
        do_reset();
        check_bank();
        `CHK("mode after reset", 1'b0, current_mode)
        tally_and_finish();
    end
endmodule : dac_code_map_tb
